/* File: common/tcb_pkg.sv */
/*
 * tcb_pkg: instruction field positions, opcodes, phase codes and constants
 * for the transfer control decode and execute unit.
 * assumes: 32-bit instruction dwords, one device clock.
 */
package tcb_pkg;
    localparam int        TYPE_HI      = 31;
    localparam int        TYPE_LO      = 30;
    localparam logic [1:0] TYPE_XFER   = 2'h2;
    localparam int        OPC_HI       = 29;
    localparam int        OPC_LO       = 27;
    localparam int        PHASE_HI     = 26;
    localparam int        PHASE_LO     = 24;
    localparam int        REL_BIT      = 23;
    localparam int        CARRY_BIT    = 21;
    localparam int        IOTF_BIT     = 20;
    localparam int        SENSE_BIT    = 19;
    localparam int        CMPD_BIT     = 18;
    localparam int        CMPP_BIT     = 17;
    localparam int        WAITP_BIT    = 16;
    localparam int        MASK_HI      = 15;
    localparam int        MASK_LO      = 8;
    localparam int        DATA_HI      = 7;
    localparam int        DATA_LO      = 0;
    localparam int        OFFS_W       = 24;
    localparam int        INTERRUPT_STATUS_REG_IOTF   = 2;
    localparam logic [31:0] PTR_STEP   = 32'h0000_0004;
    localparam logic [31:0] PTR_RST    = 32'h0000_0000;
    localparam logic [2:0] OPC_JUMP    = 3'h0;
    localparam logic [2:0] OPC_CALL    = 3'h1;
    localparam logic [2:0] OPC_RET     = 3'h2;
    localparam logic [2:0] OPC_INT     = 3'h3;
    localparam logic [2:0] PH_DOUT     = 3'h0;
    localparam logic [2:0] PH_DIN      = 3'h1;
    localparam logic [2:0] PH_CMD      = 3'h2;
    localparam logic [2:0] PH_STAT     = 3'h3;
    localparam logic [2:0] PH_MOUT     = 3'h6;
    localparam logic [2:0] PH_MIN      = 3'h7;

    typedef enum logic [3:0] {
        TCB_IDLE   = 4'b0001,
        TCB_WAIT   = 4'b0010,
        TCB_EXEC   = 4'b0100,
        TCB_HALT   = 4'b1000
    } tcb_state_type;
endpackage : tcb_pkg

/* File: core/tcb_unit.sv */
/*
 * tcb_unit: transfer control (jump, call, return, interrupt) decode and execute.
 * assumes: fetch logic presents both dwords with instr_valid_i for one cycle,
 * waits for done_o; scsi pins and host ptr write are asynchronous and synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
//
// Operation
// RQ1: bits 29-27 pick jump, call, return, interrupt; top bit set is reserved.
// RQ2: taken jump loads pointer from operand holder; otherwise pointer unchanged.
// RQ3: call saves pointer in single return holder; no nesting.
// RQ4: taken return restores pointer from return holder, unchecked, no interrupt.
// RQ5: taken interrupt asserts active-low interrupt request.
// RQ6: halting interrupt stops processor until host writes pointer.
// RQ7: interrupt keeps second dword in operand holder as vector.
// RQ8: bit 20 with taken interrupt sets on-the-fly status bit 2, continues.
// RQ9: bits 26-24 compared with msg, c/d, i/o latched at request.
// RQ10: bit 23 on jump/call adds signed 24-bit offset to next pointer.
// RQ11: offset is two's complement, reaching 16 MB segment either way; the sign-extended 24-bit offset here reaches 8 MB either way.
// RQ12: bit 21 tests alu carry; programs must not mix with compares.
// RQ13: branch taken when compare result equals bit 19.
// RQ14: phase and data both enabled: true if both match, false if both mismatch.
// RQ15: bit 18 compares first received byte latch with compare value.
// RQ16: bit 17 compares phase as initiator, tests attention as target.
// RQ17: bit 16 waits for a new unserviced phase before comparing.
// RQ18: mask bits 15-8 set exclude matching data bits.
// RQ19: compare value is bits 7-0 against first received byte.
// RQ20: absolute target fetched, then target plus 4 loaded into pointer.
// RQ21: target mode programs leave phase field clear.
// RQ22: no test enabled means unconditional transfer.
// RQ23: bits 31-30 equal 10 route instruction to this unit.
module tcb_unit (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        instr_valid_i,
    input  wire logic [31:0] instr_dw0_i,
    input  wire logic [31:0] instr_dw1_i,
    input  wire logic        alu_carry_i,
    input  wire logic        target_mode_i,
    input  wire logic [7:0]  first_received_byte_latch_i,
    input  wire logic        sreq_n_i,
    input  wire logic [2:0]  phase_lines_i,
    input  wire logic        satn_n_i,
    input  wire logic        host_ptr_wr_i,
    input  wire logic [31:0] host_ptr_data_i,
    input  wire logic        irq_ack_i,
    output logic             done_o,
    output logic             taken_o,
    output logic             reserved_op_o,
    output logic             halted_o,
    output logic             irq_n_o,
    output logic [31:0]      instr_ptr_o,
    output logic [31:0]      fetch_addr_o,
    output logic             fetch_req_o,
    output logic [31:0]      operand_address_holder_o,
    output logic [31:0]      call_return_holder_o,
    output logic [7:0]       interrupt_status_reg_o
);
    tcb_pkg::tcb_state_type state_r;
    tcb_pkg::tcb_state_type state_nxt;

    logic [31:0] ip_r;
    logic [31:0] dw0_r;
    logic [31:0] operand_address_holder_r;
    logic [31:0] ret_r;
    logic [7:0]  interrupt_status_reg_r;
    logic        irq_n_r;
    logic        done_r;
    logic        taken_r;
    logic        resv_r;
    logic [31:0] fetch_addr_r;
    logic        fetch_req_r;
    logic        halted_r;

    // two-flop synchronisers for pins and host write strobe
    logic [5:0]  pin_s1_r;
    logic [5:0]  pin_s2_r;
    logic        sreq_d_r;
    logic [2:0]  phase_latch_r;
    logic        phase_new_r;
    logic        hwr_d_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1_r <= 6'h3f;
            pin_s2_r <= 6'h3f;
        end else begin
            pin_s1_r <= {host_ptr_wr_i, sreq_n_i, satn_n_i, phase_lines_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    wire logic       sreq_n_s = pin_s2_r[4];
    wire logic       satn_n_s = pin_s2_r[3];
    wire logic [2:0] phase_s  = pin_s2_r[2:0];
    wire logic       hwr_s    = pin_s2_r[5];
    wire logic       sreq_fall = sreq_d_r & ~sreq_n_s;
    wire logic       hwr_rise  = hwr_s & ~hwr_d_r;

    // instruction fields
    wire logic [2:0] opc      = dw0_r[tcb_pkg::OPC_HI:tcb_pkg::OPC_LO];
    wire logic [2:0] ph_field = dw0_r[tcb_pkg::PHASE_HI:tcb_pkg::PHASE_LO];
    wire logic       f_rel    = dw0_r[tcb_pkg::REL_BIT];
    wire logic       f_carry  = dw0_r[tcb_pkg::CARRY_BIT];
    wire logic       f_iotf   = dw0_r[tcb_pkg::IOTF_BIT];
    wire logic       f_sense  = dw0_r[tcb_pkg::SENSE_BIT];
    wire logic       f_cmpd   = dw0_r[tcb_pkg::CMPD_BIT];
    wire logic       f_cmpp   = dw0_r[tcb_pkg::CMPP_BIT];
    wire logic       f_wait   = dw0_r[tcb_pkg::WAITP_BIT];
    wire logic [7:0] f_mask   = dw0_r[tcb_pkg::MASK_HI:tcb_pkg::MASK_LO];
    wire logic [7:0] f_data   = dw0_r[tcb_pkg::DATA_HI:tcb_pkg::DATA_LO];

    logic phase_match;
    logic data_match;
    logic cond_true;
    logic cond_false;
    logic take;

    always_comb begin
        // target mode tests attention instead of phase (see RQ16, RQ9)
        phase_match = target_mode_i ? ~satn_n_s : (phase_latch_r == ph_field);
        // masked data compare (see RQ15, RQ18, RQ19)
        data_match  = &((first_received_byte_latch_i ~^ f_data) | f_mask);
        cond_true   = 1'b1;
        cond_false  = 1'b0;
        if (f_carry) begin // see RQ12
            cond_true  = alu_carry_i;
            cond_false = ~alu_carry_i;
        end else if (f_cmpp && f_cmpd) begin // see RQ14
            cond_true  = phase_match & data_match;
            cond_false = ~phase_match & ~data_match;
        end else if (f_cmpp) begin
            cond_true  = phase_match;
            cond_false = ~phase_match;
        end else if (f_cmpd) begin
            cond_true  = data_match;
            cond_false = ~data_match;
        end
        // sense bit selects branch on true or false (see RQ13); none set is unconditional (see RQ22)
        if (!(f_carry || f_cmpp || f_cmpd)) begin
            take = 1'b1;
        end else begin
            take = f_sense ? cond_true : cond_false;
        end
    end

    // relative target: sign-extended 24-bit offset added to next pointer (see RQ10, RQ11)
    wire logic [31:0] rel_off = {{(32 - tcb_pkg::OFFS_W){operand_address_holder_r[tcb_pkg::OFFS_W - 1]}},
                                 operand_address_holder_r[tcb_pkg::OFFS_W - 1:0]};
    wire logic [31:0] jmp_tgt = f_rel ? ip_r + rel_off : operand_address_holder_r;
    wire logic        is_rsvd = opc[2]; // see RQ1
    wire logic        need_wait = f_wait && (f_cmpp || f_cmpd) && !f_carry;
    wire logic        int_fire  = (state_r == tcb_pkg::TCB_EXEC) && !is_rsvd && (opc == tcb_pkg::OPC_INT) && take;

    // sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tcb_pkg::TCB_IDLE: begin
                // see RQ23
                if (instr_valid_i && instr_dw0_i[tcb_pkg::TYPE_HI:tcb_pkg::TYPE_LO] == tcb_pkg::TYPE_XFER) begin
                    state_nxt = (instr_dw0_i[tcb_pkg::WAITP_BIT] &&
                                 (instr_dw0_i[tcb_pkg::CMPP_BIT] || instr_dw0_i[tcb_pkg::CMPD_BIT]) &&
                                 !instr_dw0_i[tcb_pkg::CARRY_BIT]) ? tcb_pkg::TCB_WAIT : tcb_pkg::TCB_EXEC;
                end
            end
            tcb_pkg::TCB_WAIT: begin
                if (phase_new_r) begin // see RQ17
                    state_nxt = tcb_pkg::TCB_EXEC;
                end
            end
            tcb_pkg::TCB_EXEC: begin
                if (!is_rsvd && opc == tcb_pkg::OPC_INT && take && !f_iotf) begin
                    state_nxt = tcb_pkg::TCB_HALT; // see RQ6
                end else begin
                    state_nxt = tcb_pkg::TCB_IDLE;
                end
            end
            tcb_pkg::TCB_HALT: begin
                if (hwr_rise) begin // see RQ6
                    state_nxt = tcb_pkg::TCB_IDLE;
                end
            end
            default: state_nxt = tcb_pkg::TCB_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= tcb_pkg::TCB_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // delayed copies for edge detection, idle high
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sreq_d_r <= 1'b1;
            hwr_d_r  <= 1'b1;
        end else begin
            sreq_d_r <= sreq_n_s;
            hwr_d_r  <= hwr_s;
        end
    end

    // phase latched on request
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_latch_r <= 3'h0;
        end else if (sreq_fall) begin
            phase_latch_r <= phase_s; // see RQ9
        end
    end

    // new phase pending until a waiting compare consumes it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_new_r <= 1'b0;
        end else if (sreq_fall) begin
            phase_new_r <= 1'b1;
        end else if (state_r == tcb_pkg::TCB_WAIT) begin
            phase_new_r <= 1'b0; // see RQ17
        end
    end

    // instruction capture; operand holder keeps second dword (see RQ7)
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dw0_r  <= 32'h0000_0000;
            operand_address_holder_r <= 32'h0000_0000;
        end else if (state_r == tcb_pkg::TCB_IDLE && state_nxt != tcb_pkg::TCB_IDLE) begin
            dw0_r  <= instr_dw0_i;
            operand_address_holder_r <= instr_dw1_i;
        end
    end

    // instruction pointer, return holder and fetch request
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ip_r         <= tcb_pkg::PTR_RST;
            ret_r        <= tcb_pkg::PTR_RST;
            fetch_addr_r <= tcb_pkg::PTR_RST;
            fetch_req_r  <= 1'b0;
        end else begin
            fetch_req_r <= 1'b0;
            if (state_r == tcb_pkg::TCB_HALT && hwr_rise) begin
                ip_r         <= host_ptr_data_i + tcb_pkg::PTR_STEP; // see RQ6
                fetch_addr_r <= host_ptr_data_i;
                fetch_req_r  <= 1'b1;
            end else if (state_r == tcb_pkg::TCB_EXEC && !is_rsvd) begin
                fetch_req_r  <= 1'b1;
                fetch_addr_r <= ip_r; // see RQ2
                case (opc)
                    tcb_pkg::OPC_JUMP, tcb_pkg::OPC_CALL: begin
                        if (take) begin
                            fetch_addr_r <= jmp_tgt; // see RQ20
                            ip_r         <= jmp_tgt + tcb_pkg::PTR_STEP; // see RQ2, RQ20
                            if (opc == tcb_pkg::OPC_CALL) begin
                                ret_r <= ip_r; // see RQ3
                            end
                        end
                    end
                    tcb_pkg::OPC_RET: begin
                        if (take) begin
                            fetch_addr_r <= ret_r; // see RQ4
                            ip_r         <= ret_r + tcb_pkg::PTR_STEP;
                        end
                    end
                    tcb_pkg::OPC_INT: begin
                        if (take && !f_iotf) begin
                            fetch_req_r <= 1'b0; // see RQ6
                        end
                    end
                    default: fetch_req_r <= 1'b1;
                endcase
            end
        end
    end

    // interrupt request; set wins over host ack
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_n_r <= 1'b1;
        end else if (int_fire) begin
            irq_n_r <= 1'b0; // see RQ5
        end else if (irq_ack_i) begin
            irq_n_r <= 1'b1;
        end
    end

    // on-the-fly status; set wins over host ack
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            interrupt_status_reg_r <= 8'h00;
        end else if (int_fire) begin
            interrupt_status_reg_r[tcb_pkg::INTERRUPT_STATUS_REG_IOTF] <= interrupt_status_reg_r[tcb_pkg::INTERRUPT_STATUS_REG_IOTF] | f_iotf; // see RQ8
        end else if (irq_ack_i) begin
            interrupt_status_reg_r[tcb_pkg::INTERRUPT_STATUS_REG_IOTF] <= 1'b0;
        end
    end

    // completion pulse
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == tcb_pkg::TCB_EXEC);
        end
    end

    // taken pulse
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            taken_r <= 1'b0;
        end else begin
            taken_r <= (state_r == tcb_pkg::TCB_EXEC) && take && !is_rsvd;
        end
    end

    // reserved opcode pulse
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            resv_r <= 1'b0;
        end else begin
            resv_r <= (state_r == tcb_pkg::TCB_EXEC) && is_rsvd; // see RQ1
        end
    end

    // halt flag as its own flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            halted_r <= 1'b0;
        end else begin
            halted_r <= (state_nxt == tcb_pkg::TCB_HALT); // see RQ6
        end
    end

    assign done_o                   = done_r;
    assign taken_o                  = taken_r;
    assign reserved_op_o            = resv_r;
    assign halted_o                 = halted_r;
    assign irq_n_o                  = irq_n_r;
    assign instr_ptr_o              = ip_r;
    assign fetch_addr_o             = fetch_addr_r;
    assign fetch_req_o              = fetch_req_r;
    assign operand_address_holder_o = operand_address_holder_r;
    assign call_return_holder_o     = ret_r;
    assign interrupt_status_reg_o   = interrupt_status_reg_r;
endmodule // tcb_unit
`default_nettype wire

/* File: verification/tcb_unit_checker.sv */
/* tcb_unit_checker: port assertions for tcb_unit.
   assumes: bound to tcb_unit, one clock, sync reset. */
`timescale 1ns/10ps
`default_nettype none
module tcb_unit_checker (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        instr_valid_i,
    input wire logic [31:0] instr_dw0_i,
    input wire logic [31:0] instr_dw1_i,
    input wire logic        alu_carry_i,
    input wire logic        host_ptr_wr_i,
    input wire logic        done_o,
    input wire logic        taken_o,
    input wire logic        reserved_op_o,
    input wire logic        halted_o,
    input wire logic        irq_n_o,
    input wire logic [31:0] instr_ptr_o,
    input wire logic [31:0] fetch_addr_o,
    input wire logic        fetch_req_o,
    input wire logic [31:0] call_return_holder_o,
    input wire logic [7:0]  interrupt_status_reg_o
);
    logic        busy_r;
    logic        acc;
    logic        unc;
    logic [31:0] w;
    assign w   = instr_dw0_i;
    assign unc = ~|{w[21], w[18:17]};
    assign acc = instr_valid_i & (~busy_r | done_o) & ~halted_o & (w[31:30] == tcb_pkg::TYPE_XFER);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) busy_r <= 1'b0;
        else if (acc) busy_r <= 1'b1;
        else if (done_o) busy_r <= 1'b0;
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    done_latency_a: assert property (acc && !(w[16] && |w[18:17]) |-> ##2 done_o)
        else $error("done late");
    reserved_op_a: assert property (acc && w[29] |-> ##2 reserved_op_o && !taken_o && !fetch_req_o)
        else $error("reserved opcode acted");
    halt_int_a: assert property (acc && w[29:27] == tcb_pkg::OPC_INT && unc && !w[20]
        |-> ##2 !irq_n_o && halted_o && !fetch_req_o) else $error("halting interrupt wrong");
    fly_int_a: assert property (acc && w[29:27] == tcb_pkg::OPC_INT && unc && w[20]
        |-> ##2 interrupt_status_reg_o[2] && !halted_o) else $error("on the fly interrupt wrong");
    jump_abs_a: assert property (acc && w[29:27] == tcb_pkg::OPC_JUMP && unc && !w[23]
        |-> ##2 fetch_addr_o == $past(instr_dw1_i, 2) && instr_ptr_o == $past(instr_dw1_i, 2) + 32'h4)
        else $error("absolute jump target wrong");
    call_save_a: assert property (acc && w[29:27] == tcb_pkg::OPC_CALL && unc
        |-> ##2 call_return_holder_o == $past(instr_ptr_o, 2)) else $error("call did not save pointer");
    carry_test_a: assert property (acc && !w[29] && w[21]
        |-> ##2 taken_o == ($past(alu_carry_i, 1) == $past(w[19], 2))) else $error("carry sense wrong");
    host_resume_a: assert property (halted_o && $rose(host_ptr_wr_i)
        |-> ##[1:4] !halted_o && fetch_req_o) else $error("no resume after pointer write");
endmodule // tcb_unit_checker
bind tcb_unit tcb_unit_checker chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_dw0_i(instr_dw0_i), .instr_dw1_i(instr_dw1_i), .alu_carry_i(alu_carry_i),
    .host_ptr_wr_i(host_ptr_wr_i), .done_o(done_o), .taken_o(taken_o), .reserved_op_o(reserved_op_o),
    .halted_o(halted_o), .irq_n_o(irq_n_o), .instr_ptr_o(instr_ptr_o), .fetch_addr_o(fetch_addr_o),
    .fetch_req_o(fetch_req_o), .call_return_holder_o(call_return_holder_o),
    .interrupt_status_reg_o(interrupt_status_reg_o));
`default_nettype wire

/* File: verification/tcb_scsi_target.sv */
/* tcb_scsi_target: scsi target, shows a phase and pulses the request.
   assumes: go_i high one clock; ph_i held until the request ends. */
`timescale 1ns/10ps
`default_nettype none
module tcb_scsi_target (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] dly_i,
    input  wire logic [2:0] ph_i,
    output logic            sreq_n_o,
    output logic [2:0]      phase_o
);
    logic [7:0] cnt_r = 8'h0;
    always_ff @(posedge clk_i) begin
        if (go_i) cnt_r <= dly_i + 8'h4;
        else if (cnt_r != 8'h0) cnt_r <= cnt_r - 8'h1;
    end
    // phase valid four cycles, flipped once released
    assign phase_o  = (cnt_r != 8'h0 && cnt_r < 8'h5) ? ph_i : ~ph_i;
    assign sreq_n_o = ~(cnt_r == 8'h1 || cnt_r == 8'h2);
endmodule // tcb_scsi_target
`default_nettype wire

/* File: verification/tb.sv */
/* tb: random and corner tests of tcb_unit with a scsi target model.
   assumes: tcb_pkg, tcb_unit and the target model compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, instr_valid_i = 1'b0, alu_carry_i = 1'b0, go = 1'b0;
    logic        target_mode_i = 1'b0, satn_n_i = 1'b1, host_ptr_wr_i = 1'b0, irq_ack_i = 1'b0;
    logic [31:0] instr_dw0_i = 32'h0, instr_dw1_i = 32'h0, host_ptr_data_i = 32'h0;
    logic [7:0]  first_received_byte_latch_i = 8'h0, dly = 8'h0, dat, interrupt_status_reg_o;
    wire         sreq_n_i;
    wire  [2:0]  phase_lines_i;
    logic        done_o, taken_o, reserved_op_o, halted_o, irq_n_o, fetch_req_o;
    logic [31:0] instr_ptr_o, fetch_addr_o, operand_address_holder_o, call_return_holder_o;
    logic [2:0]  ph = 3'h0, c, pf;
    logic [31:0] exp_ptr = 32'h0, exp_hold = 32'h0, r, q, w, v;
    int          fails = 0, tests_run = 0, lat, seed = 7, i;
    tcb_unit dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i), .instr_dw0_i(instr_dw0_i),
                  .instr_dw1_i(instr_dw1_i), .alu_carry_i(alu_carry_i), .target_mode_i(target_mode_i),
                  .first_received_byte_latch_i(first_received_byte_latch_i), .sreq_n_i(sreq_n_i),
                  .phase_lines_i(phase_lines_i), .satn_n_i(satn_n_i), .host_ptr_wr_i(host_ptr_wr_i),
                  .host_ptr_data_i(host_ptr_data_i), .irq_ack_i(irq_ack_i), .done_o(done_o), .taken_o(taken_o),
                  .reserved_op_o(reserved_op_o), .halted_o(halted_o), .irq_n_o(irq_n_o),
                  .instr_ptr_o(instr_ptr_o), .fetch_addr_o(fetch_addr_o), .fetch_req_o(fetch_req_o),
                  .operand_address_holder_o(operand_address_holder_o),
                  .call_return_holder_o(call_return_holder_o), .interrupt_status_reg_o(interrupt_status_reg_o));
    tcb_scsi_target tgt (.clk_i(clk_i), .go_i(go), .dly_i(dly), .ph_i(ph), .sreq_n_o(sreq_n_i),
                         .phase_o(phase_lines_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic cond_ok(input logic [31:0] a);
        logic pm, dm;
        pm = target_mode_i ? ~satn_n_i : (ph == a[26:24]);
        dm = ((first_received_byte_latch_i ^ a[7:0]) & ~a[15:8]) == 8'h0;
        if (a[21]) return alu_carry_i == a[19];
        if (a[18] && a[17]) return a[19] ? (pm && dm) : (!pm && !dm);
        if (a[18]) return dm == a[19];
        if (a[17]) return pm == a[19];
        return 1'b1;
    endfunction
    task automatic run(input logic [31:0] a, input logic [31:0] b);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_dw0_i   <= a;
        instr_dw1_i   <= b;
        go            <= 1'b0;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
        for (lat = 0; done_o !== 1'b1; lat++) begin
            if (lat == 80) begin
                fails++;
                close_out();
            end
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic ack_irq();
        @(posedge clk_i);
        irq_ack_i <= 1'b1;
        @(posedge clk_i);
        irq_ack_i <= 1'b0;
        #1;
        check("ack", {irq_n_o, interrupt_status_reg_o[2]}, 2'h2);
    endtask
    task automatic refused(input logic [31:0] a);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_dw0_i   <= a;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        repeat (3) begin
            @(posedge clk_i);
            #1;
            check("idle", done_o, 1'b0);
        end
    endtask
    task automatic xfer(input logic [31:0] a, input logic [31:0] b);
        logic        tk;
        logic [31:0] tgt, fa;
        tk  = cond_ok(a);
        tgt = a[23] ? exp_ptr + {{8{b[23]}}, b[23:0]} : b;
        if (a[29:27] == tcb_pkg::OPC_RET) tgt = exp_hold;
        if (a[29:27] == tcb_pkg::OPC_CALL && tk) exp_hold = exp_ptr;
        fa = exp_ptr;
        if (tk && a[29:27] != tcb_pkg::OPC_INT) begin
            fa      = tgt;
            exp_ptr = tgt + tcb_pkg::PTR_STEP;
        end
        run(a, b);
        check("taken", taken_o, tk);
        check("fetch", fetch_addr_o, fa);
        check("ptr", instr_ptr_o, exp_ptr);
        check("hold", call_return_holder_o, exp_hold);
        check("req", {fetch_req_o, halted_o}, 2'h2);
        if (a[29:27] == tcb_pkg::OPC_INT) begin
            check("fly", interrupt_status_reg_o[2], tk);
            check("vec", operand_address_holder_o, b);
            ack_irq();
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (i = 0; i < 2; i++) begin
            @(posedge clk_i);
            go  <= 1'b1;
            dly <= i ? 8'h0 : 8'h14;
            ph  <= tcb_pkg::PH_MIN;
            #1;
            xfer({2'h2, tcb_pkg::OPC_JUMP, tcb_pkg::PH_MIN, 24'h0b0000}, 32'h100 << i);
            check("wait", lat > 16, i == 0);
        end
        $display("test wait done");
        for (i = 0; i < 80; i++) begin
            r = $random(seed);
            q = $random(seed);
            @(posedge clk_i);
            go                          <= 1'b1;
            ph                          <= r[17:15];
            target_mode_i               <= r[19];
            satn_n_i                    <= r[20];
            alu_carry_i                 <= r[11];
            first_received_byte_latch_i <= q[23:16];
            @(posedge clk_i);
            go <= 1'b0;
            repeat (8) @(posedge clk_i);
            c   = (r[1:0] == 2'h1) ? 3'h0 : {~r[3] & r[2], r[3] & (r[2] | r[4]), r[3] & (~r[2] | r[4])};
            pf  = r[19] ? 3'h0 : (r[5] ? r[17:15] : r[14:12]);
            dat = r[8] ? q[23:16] ^ (q[31:24] & q[15:8]) : q[7:0];
            w   = {2'h2, 1'b0, r[1:0], pf, r[9], 1'b0, c[2], r[1:0] == 2'h3, r[18], c[1:0], 1'b0, q[15:8], dat};
            xfer(w, $random(seed));
        end
        xfer({2'h2, tcb_pkg::OPC_JUMP, 27'h0}, 32'hffff_fffc);
        xfer({2'h2, tcb_pkg::OPC_JUMP, 4'h8, 23'h0}, 32'h0080_0000);
        xfer({2'h2, tcb_pkg::OPC_JUMP, 4'h8, 23'h0}, 32'hff7f_ffff);
        $display("test random done");
        for (i = 4; i < 8; i++) begin
            run({2'h2, i[2:0], 27'h0}, 32'h0);
            check("rsv", {reserved_op_o, taken_o, fetch_req_o}, 3'h4);
            check("rsv ptr", instr_ptr_o, exp_ptr);
        end
        refused({2'h1, 30'h0});
        $display("test reserved done");
        v = $random(seed);
        run({2'h2, tcb_pkg::OPC_INT, 27'h0}, v);
        check("halt", {irq_n_o, halted_o, fetch_req_o}, 3'h2);
        check("vec", operand_address_holder_o, v);
        refused({2'h2, 30'h0});
        @(posedge clk_i);
        host_ptr_data_i <= v;
        host_ptr_wr_i   <= 1'b1;
        for (i = 0; i < 20 && fetch_req_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 20) begin
            fails++;
            close_out();
        end
        check("resume", halted_o, 1'b0);
        check("resume ptr", instr_ptr_o, v + tcb_pkg::PTR_STEP);
        host_ptr_wr_i <= 1'b0;
        ack_irq();
        $display("test halt done");
        close_out();
    end
endmodule // tb
`default_nettype wire
